// ### pkg/hbp_pkg.sv
// Notes on behaviour
// RULE_01: With register select high, a host access is steered to the host port status register.
// RULE_02: With register select low, a host write loads the bus byte into the host-to-core data register.
// RULE_03: With register select low, a host read drives a byte of the core-to-host data register onto the bus.
// RULE_04: Byte select high reaches bits 15-8 of the chosen register and low reaches bits 7-0.
// RULE_05: The data bus drivers stay off except while the host performs a read access.
// RULE_06: The host data path is eight bits wide, so each 16-bit register moves as two byte accesses.
// RULE_07: The host drives chip select and the strobes active low, one strobe at a time, both high at idle.
package hbp_pkg;
	localparam int          DATA_W       = 8;
	localparam int          REG_W        = 16;
	localparam logic        SEL_STATUS   = 1'h1;
	localparam logic        SEL_DATA     = 1'h0;
	localparam logic        BYTE_HI      = 1'h1;
	localparam logic        BYTE_LO      = 1'h0;
	localparam int          ST_IN_FULL   = 0;
	localparam int          ST_OUT_FULL  = 1;
	localparam int          ST_IN_OVR    = 2;
	localparam int          ST_OUT_UNR   = 3;
	localparam int          ST_CORE_OVR  = 4;
	localparam int          ST_USER_LSB  = 8;
	localparam int          ST_USER_W    = 8;
	localparam logic [15:0] REG_RST      = 16'h0000;
	localparam logic [7:0]  BYTE_RST     = 8'h00;

	// Byte half of a 16-bit register as seen through the 8-bit port
	function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic hi);
		pick_byte = (hi == BYTE_HI) ? word[15:8] : word[7:0];
	endfunction
endpackage

// ### pkg/hbp_acc_if.sv
`timescale 1ns/100ps
interface hbp_acc_if;
	logic       wr_pulse;
	logic       rd_pulse;
	logic       rd_active;
	logic       reg_sel;
	logic       byte_sel;
	logic [7:0] wdata;

	modport dec  (output wr_pulse, output rd_pulse, output rd_active, output reg_sel, output byte_sel, output wdata);
	modport core (input wr_pulse, input rd_pulse, input rd_active, input reg_sel, input byte_sel, input wdata);
endinterface

// ### rtl/hbp_strobe.sv
`timescale 1ns/100ps
module hbp_strobe (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Host pins
	input  wire logic       i_reg_sel,
	input  wire logic       i_byte_sel,
	input  wire logic       i_cs_n,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	input  wire logic [7:0] i_data,
	// Decoded access
	hbp_acc_if.dec          acc
);
	logic       rd_act_ff;
	logic       rd_act_d_ff;
	logic       wr_act_ff;
	logic       wr_act_d_ff;
	logic       reg_sel_ff;
	logic       byte_sel_ff;
	logic [7:0] wdata_ff;
	wire        nxt_rd_act;
	wire        nxt_wr_act;

	// Both strobes low is illegal; read wins so the bus is never left undriven mid-read
	assign nxt_rd_act = !i_cs_n && !i_rd_n; // RULE_07
	assign nxt_wr_act = !i_cs_n && !i_wr_n && i_rd_n; // RULE_07

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rd_act_ff   <= 1'b0;
			rd_act_d_ff <= 1'b0;
			wr_act_ff   <= 1'b0;
			wr_act_d_ff <= 1'b0;
			reg_sel_ff  <= 1'b0;
			byte_sel_ff <= 1'b0;
			wdata_ff    <= hbp_pkg::BYTE_RST;
		end else begin
			rd_act_ff   <= nxt_rd_act;
			rd_act_d_ff <= rd_act_ff;
			wr_act_ff   <= nxt_wr_act;
			wr_act_d_ff <= wr_act_ff;
			reg_sel_ff  <= i_reg_sel;
			byte_sel_ff <= i_byte_sel;
			wdata_ff    <= i_data;
		end
	end

	// One pulse per strobe assertion, however long the host holds it
	assign acc.rd_pulse  = rd_act_ff && !rd_act_d_ff;
	assign acc.wr_pulse  = wr_act_ff && !wr_act_d_ff;
	assign acc.rd_active = rd_act_ff;
	assign acc.reg_sel   = reg_sel_ff;
	assign acc.byte_sel  = byte_sel_ff;
	assign acc.wdata     = wdata_ff;
endmodule

// ### rtl/hbp_top.sv
`timescale 1ns/100ps
module hbp_top (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	// Host port pins
	input  wire logic        I_REGISTER_SELECT,
	input  wire logic        I_BYTE_SELECT,
	input  wire logic        I_PORT_CHIP_SELECT_N,
	input  wire logic        I_PORT_READ_STROBE_N,
	input  wire logic        I_PORT_WRITE_STROBE_N,
	input  wire logic [7:0]  I_PORT_DATA_BUS,
	output logic      [7:0]  O_PORT_DATA_BUS,
	output logic             O_PORT_DATA_BUS_OE_N,
	output logic             O_PORT_READ_ENABLE_OUT,
	output logic             O_PORT_WRITE_ENABLE_OUT,
	// Core side, host-to-core word
	output logic      [15:0] O_H2D_DATA,
	output logic             O_H2D_VALID,
	input  wire logic        I_H2D_TAKE,
	// Core side, core-to-host word
	input  wire logic [15:0] I_D2H_DATA,
	input  wire logic        I_D2H_LOAD,
	output logic             O_D2H_FULL,
	// Core side, status
	input  wire logic [7:0]  I_STATUS_USER,
	input  wire logic        I_FLAG_CLR,
	output logic      [15:0] O_STATUS
);
	hbp_acc_if acc ();

	hbp_strobe u_strobe (
		.i_clk      (I_CLK),
		.i_rst_n    (I_RST_N),
		.i_reg_sel  (I_REGISTER_SELECT),
		.i_byte_sel (I_BYTE_SELECT),
		.i_cs_n     (I_PORT_CHIP_SELECT_N),
		.i_rd_n     (I_PORT_READ_STROBE_N),
		.i_wr_n     (I_PORT_WRITE_STROBE_N),
		.i_data     (I_PORT_DATA_BUS),
		.acc        (acc)
	);

	logic [15:0] h2d_ff;
	logic [7:0]  h2d_lo_stage_ff;
	logic        in_full_ff;
	logic [15:0] d2h_ff;
	logic        out_full_ff;
	logic        in_ovr_ff;
	logic        out_unr_ff;
	logic        core_ovr_ff;
	logic [7:0]  user_ff;
	logic [7:0]  dout_ff;
	logic        oe_n_ff;
	logic        rd_en_ff;
	logic        wr_en_ff;
	logic [15:0] status_out_ff;

	wire         wr_data;
	wire         wr_data_lo;
	wire         wr_data_hi;
	wire         rd_data_pulse;
	wire         rd_data_hi;
	wire         word_in_done;
	wire         word_out_done;
	wire         core_load_ok;
	wire         in_set;
	wire         in_clr;
	wire         out_set;
	wire         out_clr;
	wire         in_ovr_set;
	wire         out_unr_set;
	wire         core_ovr_set;
	wire [15:0]  status_word;
	wire [15:0]  read_word;
	wire [7:0]  read_byte;
	wire         nxt_in_full;
	wire         nxt_out_full;
	wire         nxt_in_ovr;
	wire         nxt_out_unr;
	wire         nxt_core_ovr;
	wire [15:0]  nxt_h2d;
	wire [7:0]   nxt_h2d_lo_stage;
	wire [15:0]  nxt_d2h;
	wire [7:0]   nxt_dout;
	wire         nxt_oe_n;

	// Host writes to status are not meaningful and are dropped
	assign wr_data    = acc.wr_pulse && (acc.reg_sel == hbp_pkg::SEL_DATA); // RULE_02
	assign wr_data_lo = wr_data && (acc.byte_sel == hbp_pkg::BYTE_LO); // RULE_04
	assign wr_data_hi = wr_data && (acc.byte_sel == hbp_pkg::BYTE_HI); // RULE_04

	// The upper byte closes a word; a full register refuses it so the core never sees a torn word
	assign word_in_done = wr_data_hi && !in_full_ff; // RULE_06
	assign in_ovr_set   = wr_data_hi && in_full_ff;

	assign nxt_h2d_lo_stage = wr_data_lo ? acc.wdata : h2d_lo_stage_ff; // RULE_06
	assign nxt_h2d          = word_in_done ? {acc.wdata, h2d_lo_stage_ff} : h2d_ff; // RULE_02

	assign in_set      = word_in_done;
	assign in_clr      = I_H2D_TAKE;
	// Set needs an empty register, so a word landing with the take of a full one is refused and flagged
	assign nxt_in_full = in_set || (in_full_ff && !in_clr);

	// Host read of the data register: the upper byte ends the word
	assign rd_data_pulse = acc.rd_pulse && (acc.reg_sel == hbp_pkg::SEL_DATA); // RULE_03
	assign rd_data_hi    = rd_data_pulse && (acc.byte_sel == hbp_pkg::BYTE_HI); // RULE_06
	assign word_out_done = rd_data_hi && out_full_ff;
	assign out_unr_set   = rd_data_hi && !out_full_ff;

	// Core may load only an empty register; a refused load only raises a flag
	assign core_load_ok = I_D2H_LOAD && !out_full_ff;
	assign core_ovr_set = I_D2H_LOAD && out_full_ff;
	assign nxt_d2h      = core_load_ok ? I_D2H_DATA : d2h_ff;

	assign out_set      = core_load_ok;
	assign out_clr      = word_out_done;
	assign nxt_out_full = out_set || (out_full_ff && !out_clr);

	// Sticky error flags, set beats the core's clear
	assign nxt_in_ovr   = in_ovr_set || (in_ovr_ff && !I_FLAG_CLR);
	assign nxt_out_unr  = out_unr_set || (out_unr_ff && !I_FLAG_CLR);
	assign nxt_core_ovr = core_ovr_set || (core_ovr_ff && !I_FLAG_CLR);

	assign status_word = {user_ff, 3'h0,
		core_ovr_ff, out_unr_ff, in_ovr_ff, out_full_ff, in_full_ff};

	// Register choice for the read path, then byte half
	assign read_word = (acc.reg_sel == hbp_pkg::SEL_STATUS) ? status_word : d2h_ff; // RULE_01 RULE_03
	assign read_byte = hbp_pkg::pick_byte(read_word, acc.byte_sel); // RULE_04

	// Drive only while a read strobe is held; data tracks live status during the strobe
	assign nxt_oe_n = !acc.rd_active; // RULE_05
	assign nxt_dout = acc.rd_active ? read_byte : hbp_pkg::BYTE_RST; // RULE_05

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			h2d_ff          <= hbp_pkg::REG_RST;
			h2d_lo_stage_ff <= hbp_pkg::BYTE_RST;
			in_full_ff      <= 1'b0;
			d2h_ff          <= hbp_pkg::REG_RST;
			out_full_ff     <= 1'b0;
		end else begin
			h2d_ff          <= nxt_h2d;
			h2d_lo_stage_ff <= nxt_h2d_lo_stage;
			in_full_ff      <= nxt_in_full;
			d2h_ff          <= nxt_d2h;
			out_full_ff     <= nxt_out_full;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			in_ovr_ff   <= 1'b0;
			out_unr_ff  <= 1'b0;
			core_ovr_ff <= 1'b0;
			user_ff     <= hbp_pkg::BYTE_RST;
		end else begin
			in_ovr_ff   <= nxt_in_ovr;
			out_unr_ff  <= nxt_out_unr;
			core_ovr_ff <= nxt_core_ovr;
			user_ff     <= I_STATUS_USER;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			dout_ff       <= hbp_pkg::BYTE_RST;
			oe_n_ff       <= 1'b1;
			rd_en_ff      <= 1'b0;
			wr_en_ff      <= 1'b0;
			status_out_ff <= hbp_pkg::REG_RST;
		end else begin
			dout_ff       <= nxt_dout; // RULE_05
			oe_n_ff       <= nxt_oe_n; // RULE_05
			rd_en_ff      <= nxt_out_full;
			wr_en_ff      <= !nxt_in_full;
			status_out_ff <= {user_ff, 3'h0, nxt_core_ovr, nxt_out_unr, nxt_in_ovr, nxt_out_full, nxt_in_full};
		end
	end

	assign O_PORT_DATA_BUS         = dout_ff;
	assign O_PORT_DATA_BUS_OE_N    = oe_n_ff;
	assign O_PORT_READ_ENABLE_OUT  = rd_en_ff;
	assign O_PORT_WRITE_ENABLE_OUT = wr_en_ff;
	assign O_H2D_DATA              = h2d_ff;
	assign O_H2D_VALID             = in_full_ff;
	assign O_D2H_FULL              = out_full_ff;
	assign O_STATUS                = status_out_ff;
endmodule

// ### tb/hbp_monitor.sv
`timescale 1ns/100ps
module hbp_mon (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Host pins
	input wire logic I_REGISTER_SELECT,
	input wire logic I_BYTE_SELECT,
	input wire logic I_PORT_CHIP_SELECT_N,
	input wire logic I_PORT_READ_STROBE_N,
	input wire logic I_PORT_WRITE_STROBE_N,
	input wire logic O_PORT_DATA_BUS_OE_N,
	// Core side
	input wire logic O_H2D_VALID,
	input wire logic I_H2D_TAKE,
	input wire logic O_D2H_FULL,
	input wire logic I_D2H_LOAD
);
	wire rd_on = !I_PORT_CHIP_SELECT_N && !I_PORT_READ_STROBE_N;
	wire wr_on = !I_PORT_CHIP_SELECT_N && !I_PORT_WRITE_STROBE_N && I_PORT_READ_STROBE_N;
	wire dat_hi = !I_REGISTER_SELECT && I_BYTE_SELECT;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	bus_drive_a: assert property (rd_on |-> ##2 !O_PORT_DATA_BUS_OE_N) else $error("read not driven");
	bus_float_a: assert property (!rd_on |-> ##2 O_PORT_DATA_BUS_OE_N) else $error("bus driven idle");
	word_done_a: assert property (wr_on && !$past(wr_on) && dat_hi && !O_H2D_VALID && !I_H2D_TAKE
		|-> ##[1:2] O_H2D_VALID) else $error("word not completed");
	low_half_a: assert property (wr_on && !$past(wr_on) && !I_REGISTER_SELECT && !I_BYTE_SELECT && !O_H2D_VALID
		|=> !O_H2D_VALID ##1 !O_H2D_VALID) else $error("low byte completed word");
	status_wr_a: assert property (wr_on && I_REGISTER_SELECT && !O_H2D_VALID
		|=> !O_H2D_VALID ##1 !O_H2D_VALID) else $error("status write taken");
	word_read_a: assert property (rd_on && !$past(rd_on) && dat_hi && O_D2H_FULL && !I_D2H_LOAD
		|-> ##[1:2] !O_D2H_FULL) else $error("word not emptied");
	cover property (rd_on && I_REGISTER_SELECT);
	cover property (wr_on && dat_hi && O_H2D_VALID);
	cover property ($fell(O_D2H_FULL));
endmodule
bind hbp_top hbp_mon i_mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REGISTER_SELECT(I_REGISTER_SELECT),
	.I_BYTE_SELECT(I_BYTE_SELECT), .I_PORT_CHIP_SELECT_N(I_PORT_CHIP_SELECT_N),
	.I_PORT_READ_STROBE_N(I_PORT_READ_STROBE_N), .I_PORT_WRITE_STROBE_N(I_PORT_WRITE_STROBE_N),
	.O_PORT_DATA_BUS_OE_N(O_PORT_DATA_BUS_OE_N), .O_H2D_VALID(O_H2D_VALID), .I_H2D_TAKE(I_H2D_TAKE),
	.O_D2H_FULL(O_D2H_FULL), .I_D2H_LOAD(I_D2H_LOAD));

// ### tb/hbp_host.sv
`timescale 1ns/100ps
module hbp_host (
	// Clock and device drive
	input  wire logic [7:0] i_q,
	input  wire logic       i_oe_n,
	input  wire logic       i_clk,
	// Host pins
	output logic            o_cs_n,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic            o_rsel,
	output logic            o_bsel,
	output logic [7:0]      o_bus
);
	logic [7:0] drv = 8'h00;
	logic       wr_on = 1'b0;
	// A floating bus shows the inverse of the last byte, never a stale copy
	assign o_bus = !i_oe_n ? i_q : (wr_on ? drv : ~drv);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_rsel = 1'b0;
		o_bsel = 1'b0;
	end
	task automatic acc(input logic w, input logic s, input logic b, input logic [7:0] d, output logic [7:0] q);
		@(negedge i_clk);
		o_rsel = s;
		o_bsel = b;
		drv = d;
		wr_on = w;
		o_cs_n = 1'b0;
		o_rd_n = w;
		o_wr_n = !w;
		repeat (2) @(posedge i_clk);
		// Read data is launched by the second edge, so take it once it has settled
		@(negedge i_clk);
		q = o_bus;
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		wr_on = 1'b0;
		@(negedge i_clk);
	endtask
endmodule

// ### tb/hbp_top_tb.sv
`timescale 1ns/100ps
module hbp_top_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        take = 1'b0;
	logic        load = 1'b0;
	logic        clr = 1'b0;
	logic [15:0] d2h = 16'h0000;
	logic [7:0]  user = 8'h00;
	logic        cs_n, rd_n, wr_n, rsel, bsel, oe_n, re_o, we_o, h2d_v, d2h_f;
	logic [7:0]  bus, dq, q;
	logic [15:0] h2d, stat;
	int          err_total = 0;
	int          checks = 0;
	hbp_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_REGISTER_SELECT(rsel), .I_BYTE_SELECT(bsel),
		.I_PORT_CHIP_SELECT_N(cs_n), .I_PORT_READ_STROBE_N(rd_n), .I_PORT_WRITE_STROBE_N(wr_n),
		.I_PORT_DATA_BUS(bus), .O_PORT_DATA_BUS(dq), .O_PORT_DATA_BUS_OE_N(oe_n), .O_PORT_READ_ENABLE_OUT(re_o),
		.O_PORT_WRITE_ENABLE_OUT(we_o), .O_H2D_DATA(h2d), .O_H2D_VALID(h2d_v), .I_H2D_TAKE(take),
		.I_D2H_DATA(d2h), .I_D2H_LOAD(load), .O_D2H_FULL(d2h_f), .I_STATUS_USER(user), .I_FLAG_CLR(clr),
		.O_STATUS(stat));
	hbp_host i_host (.i_q(dq), .i_oe_n(oe_n), .i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_rsel(rsel), .o_bsel(bsel), .o_bus(bus));
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic conclude();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic t_write();
		i_host.acc(1'b1, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_LO, 8'h34, q);
		chk("valid_lo", 16'(h2d_v), 16'h0000);
		i_host.acc(1'b1, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_HI, 8'h12, q);
		chk("h2d", h2d, 16'h1234);
		chk("we_full", 16'(we_o), 16'h0000);
		// Second word while full is dropped and flagged
		i_host.acc(1'b1, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_LO, 8'h78, q);
		i_host.acc(1'b1, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_HI, 8'h56, q);
		chk("h2d_kept", h2d, 16'h1234);
		chk("ovr", 16'(stat[hbp_pkg::ST_IN_OVR]), 16'h0001);
		pulse(take);
		pulse(clr);
		chk("taken", 16'(h2d_v), 16'h0000);
		chk("ovr_clr", 16'(stat[hbp_pkg::ST_IN_OVR]), 16'h0000);
	endtask
	task automatic t_read();
		d2h = 16'hA55A;
		pulse(load);
		chk("re_full", 16'(re_o), 16'h0001);
		i_host.acc(1'b0, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_LO, 8'h00, q);
		chk("rd_lo", 16'(q), 16'h005A);
		i_host.acc(1'b0, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_HI, 8'h00, q);
		chk("rd_hi", 16'(q), 16'h00A5);
		chk("emptied", 16'(d2h_f), 16'h0000);
		// Drivers turn off one edge after the released strobe is seen
		@(negedge clk);
		chk("oe_off", 16'(oe_n), 16'h0001);
	endtask
	task automatic t_refuse();
		i_host.acc(1'b0, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_HI, 8'h00, q);
		chk("unr_q", 16'(q), 16'h00A5);
		chk("unr", 16'(stat[hbp_pkg::ST_OUT_UNR]), 16'h0001);
		d2h = 16'h0F0F;
		pulse(load);
		d2h = 16'hF0F0;
		pulse(load);
		chk("core_ovr", 16'(stat[hbp_pkg::ST_CORE_OVR]), 16'h0001);
		i_host.acc(1'b0, hbp_pkg::SEL_DATA, hbp_pkg::BYTE_LO, 8'h00, q);
		chk("kept_lo", 16'(q), 16'h000F);
		pulse(clr);
		chk("flags_clr", stat, 16'hC302);
	endtask
	task automatic t_status();
		user = 8'hC3;
		i_host.acc(1'b0, hbp_pkg::SEL_STATUS, hbp_pkg::BYTE_HI, 8'h00, q);
		chk("st_hi", 16'(q), 16'h00C3);
		i_host.acc(1'b0, hbp_pkg::SEL_STATUS, hbp_pkg::BYTE_LO, 8'h00, q);
		chk("st_lo", 16'(q), 16'h0000);
		i_host.acc(1'b1, hbp_pkg::SEL_STATUS, hbp_pkg::BYTE_HI, 8'hFF, q);
		chk("st_wr", 16'(h2d_v), 16'h0000);
	endtask
	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("rst_oe", 16'(oe_n), 16'h0001);
		chk("rst_st", stat, 16'h0000);
		t_write();
		t_read();
		t_status();
		t_refuse();
		conclude();
	end
	initial begin
		#100000;
		err_total++;
		conclude();
	end
endmodule
